/* design/tboc_consts.vh */
// constants for the t1 bit-oriented code controller
`ifndef TBOC_CONSTS_VH
`define TBOC_CONSTS_VH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define TBOC_OFF_STATUS    8'h24
`define TBOC_OFF_MASK      8'h25
`define TBOC_OFF_CTRL      8'h37
`define TBOC_OFF_RX_MSG    8'hc0
`define TBOC_OFF_TX_MSG    8'hc1
`define TBOC_OFF_MATCH_A   8'hc2
`define TBOC_OFF_MATCH_B   8'hc3
`define TBOC_OFF_STAT_TWO  8'h14

// ------------------------------------------------------------------
// control bits
// ------------------------------------------------------------------
`define TBOC_CTRL_SEND     0
`define TBOC_CTRL_FILT_LO  1
`define TBOC_CTRL_FILT_HI  2
`define TBOC_CTRL_RX_RST   3
`define TBOC_CTRL_RX_EN    4

// ------------------------------------------------------------------
// status / mask bits
// ------------------------------------------------------------------
`define TBOC_EV_CHANGE     0
`define TBOC_EV_MATCH      1
`define TBOC_EV_TX_EMPTY   2
`define TBOC_EV_RX_FULL    3
`define TBOC_EV_ABORT      4
`define TBOC_EV_CLEAR      5
`define TBOC_STAT_TWO_VLD  7

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define TBOC_RST_REG       8'h00
`define TBOC_CODE_PRESET   6'h3f

// ------------------------------------------------------------------
// counts
// ------------------------------------------------------------------
`define TBOC_WORD_BITS     5'd16
`define TBOC_ABORT_ONES    4'd8
`define TBOC_CLEAR_BITS    5'd30
`define TBOC_FILT_NONE     3'd1
`define TBOC_FILT_01       3'd3
`define TBOC_FILT_10       3'd5
`define TBOC_FILT_11       3'd7

`endif

/* design/tboc_filter.v */
// integration filter that validates received bit-oriented codes
`timescale 1ns/1ps
`include "tboc_consts.vh"

module tboc_filter (
  input  wire       mclk_i,
  input  wire       rst_n_i,
  input  wire       clr_i,
  input  wire       word_ok_i,
  input  wire       word_err_i,
  input  wire [5:0] code_i,
  input  wire [2:0] need_i,
  output reg  [5:0] code_o,
  output reg        valid_o,
  output reg        change_o
);

  reg  [5:0] cand;
  reg  [2:0] cnt;
  wire       same = (code_i == cand);
  wire [2:0] next_cnt = same ? ((cnt == 3'd7) ? cnt : cnt + 3'd1) : 3'd1;

  always @(posedge mclk_i) begin
    if (!rst_n_i || clr_i) begin
      cand     <= `TBOC_CODE_PRESET;
      cnt      <= 3'd0;
      code_o   <= `TBOC_CODE_PRESET;
      valid_o  <= 1'b0;
      change_o <= 1'b0;
    end else begin
      change_o <= 1'b0;
      if (word_ok_i) begin
        cand <= code_i;
        cnt  <= next_cnt;
        // a code counts once it has persisted the selected number of words
        if (next_cnt == need_i && (!valid_o || code_i != code_o)) begin
          code_o   <= code_i;
          valid_o  <= 1'b1;
          change_o <= 1'b1;
        end
      end else if (word_err_i) begin
        cnt <= 3'd0;
        // a broken word drops a held code back to the preset
        if (valid_o) begin
          code_o   <= `TBOC_CODE_PRESET;
          valid_o  <= 1'b0;
          change_o <= 1'b1;
        end
      end
    end
  end

endmodule

/* design/tboc_ctrl.v */
// bit-oriented code generator and detector with host registers
`timescale 1ns/1ps
`include "tboc_consts.vh"

module tboc_ctrl (
  input  wire       mclk_i,
  input  wire       rst_n_i,
  input  wire       t1_mode_i,
  input  wire [7:0] addr_i,
  input  wire       wr_i,
  input  wire [7:0] wdata_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  input  wire       tx_bit_req_i,
  output reg        tx_bit_o,
  input  wire       rx_bit_valid_i,
  input  wire       rx_bit_i,
  output wire       irq_n_o
);

  // ------------------------------------------------------------------
  // host registers
  // ------------------------------------------------------------------
  reg  [7:0] ctrl;
  reg  [7:0] mask;
  reg  [7:0] status;
  reg  [7:0] tx_msg;
  reg  [7:0] match_a;
  reg  [7:0] match_b;
  reg        rx_rst_prev;
  reg        rx_en_prev;
  wire [5:0] rx_code;
  wire       rx_valid;
  wire [7:0] rx_msg = {2'b00, rx_code};

  wire send_on  = ctrl[`TBOC_CTRL_SEND] & t1_mode_i;
  wire rx_on    = ctrl[`TBOC_CTRL_RX_EN] & t1_mode_i;
  wire wr_ctrl  = wr_i && (addr_i == `TBOC_OFF_CTRL);
  wire rd_stat  = rd_i && (addr_i == `TBOC_OFF_STATUS);

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ctrl    <= `TBOC_RST_REG;
      mask    <= `TBOC_RST_REG;
      tx_msg  <= `TBOC_RST_REG;
      match_a <= `TBOC_RST_REG;
      match_b <= `TBOC_RST_REG;
    end else if (wr_i) begin
      case (addr_i)
        // upper control bits are not stored, keeping them at zero
        `TBOC_OFF_CTRL:    ctrl    <= {3'b000, wdata_i[4:0]};
        `TBOC_OFF_MASK:    mask    <= {2'b00, wdata_i[5:0]};
        `TBOC_OFF_TX_MSG:  tx_msg  <= wdata_i;
        `TBOC_OFF_MATCH_A: match_a <= wdata_i;
        `TBOC_OFF_MATCH_B: match_b <= wdata_i;
        default:           ctrl    <= ctrl;
      endcase
    end
  end

  // read data is held in a flop, one cycle after the strobe
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `TBOC_OFF_STATUS:   rdata_o <= status;
        `TBOC_OFF_MASK:     rdata_o <= mask;
        `TBOC_OFF_CTRL:     rdata_o <= ctrl;
        `TBOC_OFF_RX_MSG:   rdata_o <= rx_msg;
        `TBOC_OFF_TX_MSG:   rdata_o <= tx_msg;
        `TBOC_OFF_MATCH_A:  rdata_o <= match_a;
        `TBOC_OFF_MATCH_B:  rdata_o <= match_b;
        `TBOC_OFF_STAT_TWO: rdata_o <= {rx_valid, 7'h00};
        default:            rdata_o <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // rx reset and enable edges
  // ------------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rx_rst_prev <= 1'b0;
      rx_en_prev  <= 1'b0;
    end else begin
      rx_rst_prev <= ctrl[`TBOC_CTRL_RX_RST];
      rx_en_prev  <= rx_on;
    end
  end

  // a held-high reset bit does nothing more; host must toggle it again
  wire rx_clr = (ctrl[`TBOC_CTRL_RX_RST] & ~rx_rst_prev)
              | (rx_on & ~rx_en_prev)
              | ~rx_on;

  // ------------------------------------------------------------------
  // transmit generator
  // ------------------------------------------------------------------
  localparam TX_IDLE = 2'b01;
  localparam TX_SEND = 2'b10;

  reg  [1:0]  tx_state;
  reg  [15:0] tx_sh;
  reg  [3:0]  tx_cnt;
  reg         ev_tx_empty;
  // eight-one flag first, then a zero, six code bits lsb first, a zero
  wire [15:0] tx_word = {8'hff, 1'b0, tx_msg[0], tx_msg[1], tx_msg[2],
                         tx_msg[3], tx_msg[4], tx_msg[5], 1'b0};

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tx_state    <= TX_IDLE;
      tx_sh       <= 16'hffff;
      tx_cnt      <= 4'h0;
      tx_bit_o    <= 1'b1;
      ev_tx_empty <= 1'b0;
    end else begin
      ev_tx_empty <= 1'b0;
      case (tx_state)
        TX_IDLE: begin
          if (tx_bit_req_i) begin
            tx_bit_o <= 1'b1;
          end
          if (send_on) begin
            // load right away, first bit goes out on the next request
            tx_state    <= TX_SEND;
            tx_sh       <= tx_word;
            tx_cnt      <= 4'h0;
            ev_tx_empty <= 1'b1;
          end
        end
        TX_SEND: begin
          if (!send_on) begin
            // stop mid-word; the line idles at ones, which the far end sees as abort
            tx_state <= TX_IDLE;
            if (tx_bit_req_i) begin
              tx_bit_o <= 1'b1;
            end
          end else if (tx_bit_req_i) begin
            tx_bit_o <= tx_sh[15];
            tx_cnt   <= tx_cnt + 4'h1;
            if (tx_cnt == 4'hf) begin
              // reload so the code repeats for as long as send_on stays set
              tx_sh       <= tx_word;
              ev_tx_empty <= 1'b1;
            end else begin
              tx_sh <= {tx_sh[14:0], 1'b1};
            end
          end
        end
        default: begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // receive word framing
  // ------------------------------------------------------------------
  reg  [15:0] rx_sh;
  reg  [4:0]  word_cnt;
  reg         locked;
  reg  [3:0]  ones_cnt;
  reg  [4:0]  clr_cnt;
  reg         ev_abort;
  reg         ev_clear;
  reg         word_ok;
  reg         word_err;
  reg  [5:0]  word_code;
  wire [15:0] next_sh = {rx_sh[14:0], rx_bit_i};
  wire        is_word = (next_sh[15:8] == 8'hff) && !next_sh[7] && !next_sh[0];
  wire        rx_take = rx_bit_valid_i & rx_on;

  always @(posedge mclk_i) begin
    if (!rst_n_i || rx_clr) begin
      rx_sh     <= 16'h0000;
      word_cnt  <= 5'd0;
      locked    <= 1'b0;
      ones_cnt  <= 4'h0;
      clr_cnt   <= 5'd0;
      ev_abort  <= 1'b0;
      ev_clear  <= 1'b0;
      word_ok   <= 1'b0;
      word_err  <= 1'b0;
      word_code <= `TBOC_CODE_PRESET;
    end else begin
      word_ok  <= 1'b0;
      word_err <= 1'b0;
      ev_abort <= 1'b0;
      ev_clear <= 1'b0;
      if (rx_take) begin
        rx_sh <= next_sh;
        // eight ones in a row is an abort; count restarts after a zero
        if (!rx_bit_i) begin
          ones_cnt <= 4'h0;
        end else if (ones_cnt != `TBOC_ABORT_ONES) begin
          ones_cnt <= ones_cnt + 4'h1;
          if (ones_cnt == `TBOC_ABORT_ONES - 4'h1) begin
            ev_abort <= 1'b1;
          end
        end
        // quiet period since the last abort ends the code, flagged once
        if (rx_bit_i && ones_cnt == `TBOC_ABORT_ONES - 4'h1) begin
          clr_cnt <= 5'd0;
        end else if (clr_cnt != `TBOC_CLEAR_BITS) begin
          clr_cnt <= clr_cnt + 5'd1;
          if (clr_cnt == `TBOC_CLEAR_BITS - 5'd1) begin
            ev_clear <= 1'b1;
          end
        end
        if (is_word) begin
          word_ok   <= 1'b1;
          word_code <= {next_sh[1], next_sh[2], next_sh[3],
                        next_sh[4], next_sh[5], next_sh[6]};
          locked    <= 1'b1;
          word_cnt  <= 5'd0;
        end else if (locked) begin
          if (word_cnt == `TBOC_WORD_BITS - 5'd1) begin
            // the expected word did not arrive: non-valid code
            word_err <= 1'b1;
            locked   <= 1'b0;
            word_cnt <= 5'd0;
          end else begin
            word_cnt <= word_cnt + 5'd1;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // integration filter
  // ------------------------------------------------------------------
  reg [2:0] need;
  wire      rx_change;

  always @* begin
    case (ctrl[`TBOC_CTRL_FILT_HI:`TBOC_CTRL_FILT_LO])
      2'b00:   need = `TBOC_FILT_NONE;
      2'b01:   need = `TBOC_FILT_01;
      2'b10:   need = `TBOC_FILT_10;
      default: need = `TBOC_FILT_11;
    endcase
  end

  tboc_filter u_filter (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n_i),
    .clr_i      (rx_clr),
    .word_ok_i  (word_ok),
    .word_err_i (word_err),
    .code_i     (word_code),
    .need_i     (need),
    .code_o     (rx_code),
    .valid_o    (rx_valid),
    .change_o   (rx_change)
  );

  // ------------------------------------------------------------------
  // match detect on message updates
  // ------------------------------------------------------------------
  reg       rx_change_d;
  wire      ev_match = rx_change_d &&
                       (rx_msg == match_a || rx_msg == match_b);

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rx_change_d <= 1'b0;
    end else begin
      rx_change_d <= rx_change;
    end
  end

  // ------------------------------------------------------------------
  // event status and interrupt
  // ------------------------------------------------------------------
  wire [7:0] ev_set;
  assign ev_set[`TBOC_EV_CHANGE]   = rx_change;
  assign ev_set[`TBOC_EV_MATCH]    = ev_match;
  assign ev_set[`TBOC_EV_TX_EMPTY] = ev_tx_empty;
  assign ev_set[`TBOC_EV_RX_FULL]  = rx_change;
  assign ev_set[`TBOC_EV_ABORT]    = ev_abort;
  assign ev_set[`TBOC_EV_CLEAR]    = ev_clear;
  assign ev_set[7:6]               = 2'b00;

  // cleared by reading; a set in the read cycle survives the clear
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      status <= `TBOC_RST_REG;
    end else if (rd_stat) begin
      status <= ev_set;
    end else begin
      status <= status | ev_set;
    end
  end

  assign irq_n_o = ~|(status & mask);

endmodule

/* dv/tboc_ctrl_checker.sv */
// port assertions for the bit-oriented code controller
`timescale 1ns/1ps
module tboc_ctrl_chk (
  input wire       mclk_i,
  input wire       rst_n_i,
  input wire       t1_mode_i,
  input wire [7:0] addr_i,
  input wire       wr_i,
  input wire [7:0] wdata_i,
  input wire       rd_i,
  input wire [7:0] rdata_o,
  input wire       tx_bit_req_i,
  input wire       tx_bit_o,
  input wire       rx_bit_valid_i,
  input wire       rx_bit_i,
  input wire       irq_n_o
);
  // ----
  // shadow of host writes
  // ----
  reg [4:0] ctrl;
  reg [5:0] mask;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ctrl <= 5'h00;
      mask <= 6'h00;
    end else if (wr_i) begin
      if (addr_i == 8'h37)
        ctrl <= wdata_i[4:0];
      if (addr_i == 8'h25)
        mask <= wdata_i[5:0];
    end
  end
  rst_quiet_a: assert property ($rose(rst_n_i) |-> tx_bit_o && irq_n_o && !rdata_o)
    else $error("outputs not idle after reset");
  e1_idle_a: assert property (!t1_mode_i && tx_bit_req_i |=> tx_bit_o)
    else $error("code sent in e1 mode");
  send_off_a: assert property (tx_bit_req_i && !ctrl[0] && !$past(ctrl[0]) |=> tx_bit_o)
    else $error("code sent while send is off");
  mask_rd_a: assert property (rd_i && addr_i == 8'h25 |=> rdata_o == {2'b00, mask})
    else $error("mask readback wrong");
  ctrl_rd_a: assert property (rd_i && addr_i == 8'h37 |=> rdata_o == {3'b000, ctrl})
    else $error("control readback wrong");
  rx_top_a: assert property (rd_i && addr_i == 8'hc0 |=> rdata_o[7:6] == 2'b00)
    else $error("rx message top bits set");
  rx_preset_a: assert property (rd_i && addr_i == 8'hc0 && !ctrl[4] && !$past(ctrl[4])
    |=> rdata_o == 8'h3f) else $error("rx code not preset");
  irq_mask_a: assert property (mask == 6'h00 |-> irq_n_o)
    else $error("interrupt with all events masked");
endmodule
bind tboc_ctrl tboc_ctrl_chk CHK (.mclk_i, .rst_n_i, .t1_mode_i, .addr_i, .wr_i, .wdata_i,
  .rd_i, .rdata_o, .tx_bit_req_i, .tx_bit_o, .rx_bit_valid_i, .rx_bit_i, .irq_n_o);

/* dv/tboc_far.sv */
// remote terminal model at the far end of the data link
`timescale 1ns/1ps
module tboc_far (
  input  wire mclk_i,
  input  wire txd_i,
  output reg  req_o,
  output reg  rxv_o,
  output reg  rxd_o
);
  initial begin
    req_o = 1'b0;
    rxv_o = 1'b0;
    rxd_o = 1'b0;
  end
  // ----
  // receive feed
  // ----
  // data shows the inverse once valid drops, so no stale bit is caught
  task put(input b);
    begin
      @(posedge mclk_i);
      #1;
      rxv_o = 1'b1;
      rxd_o = b;
      @(posedge mclk_i);
      #1;
      rxv_o = 1'b0;
      rxd_o = ~b;
    end
  endtask
  task word(input [5:0] c);
    reg [15:0] w;
    integer    i;
    begin
      w = {1'b0, c, 1'b0, 8'hff};
      for (i = 0; i < 16; i = i + 1)
        put(w[i]);
    end
  endtask
  task zeros(input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1)
        put(1'b0);
    end
  endtask
  // ----
  // transmit pull
  // ----
  task take(output b);
    begin
      @(posedge mclk_i);
      #1;
      req_o = 1'b1;
      @(posedge mclk_i);
      #1;
      req_o = 1'b0;
      b = txd_i;
    end
  endtask
endmodule

/* dv/tboc_ctrl_tb_top.sv */
// self-checking bench for the bit-oriented code controller
`timescale 1ns/1ps
module tboc_ctrl_tb_top;
  reg        mclk_i;
  reg        rst_n_i;
  reg        t1_mode_i;
  reg  [7:0] addr_i;
  reg        wr_i;
  reg  [7:0] wdata_i;
  reg        rd_i;
  wire [7:0] rdata_o;
  wire       tx_bit_req_i;
  wire       tx_bit_o;
  wire       rx_bit_valid_i;
  wire       rx_bit_i;
  wire       irq_n_o;
  integer    fails;
  integer    n_compared;
  reg  [7:0] s;
  reg        b;
  tboc_ctrl DUT (.mclk_i, .rst_n_i, .t1_mode_i, .addr_i, .wr_i, .wdata_i, .rd_i, .rdata_o,
    .tx_bit_req_i, .tx_bit_o, .rx_bit_valid_i, .rx_bit_i, .irq_n_o);
  tboc_far FAR (.mclk_i(mclk_i), .txd_i(tx_bit_o), .req_o(tx_bit_req_i),
    .rxv_o(rx_bit_valid_i), .rxd_o(rx_bit_i));
  always #2.5 mclk_i = ~mclk_i;
  // ----
  // host access and compare
  // ----
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk_i);
      #1;
      wr_i = 1'b1;
      addr_i = a;
      wdata_i = d;
      @(posedge mclk_i);
      #1;
      wr_i = 1'b0;
    end
  endtask
  task rdm(input [7:0] a, input [7:0] m, input [7:0] e);
    begin
      @(posedge mclk_i);
      #1;
      rd_i = 1'b1;
      addr_i = a;
      @(posedge mclk_i);
      #1;
      rd_i = 1'b0;
      chk(rdata_o & m, e);
    end
  endtask
  // ----
  // scenarios
  // ----
  task t_regs;
    begin
      rdm(8'h24, 8'hff, 8'h00);
      rdm(8'hc0, 8'hff, 8'h3f);
      wr(8'h25, 8'hff);
      rdm(8'h25, 8'hff, 8'h3f);
      wr(8'h37, 8'he0);
      rdm(8'h37, 8'hff, 8'h00);
      rdm(8'h55, 8'hff, 8'h00);
      wr(8'hc1, 8'h15);
      rdm(8'hc1, 8'hff, 8'h15);
      wr(8'hc3, 8'h5a);
      rdm(8'hc3, 8'hff, 8'h5a);
      wr(8'h25, 8'h00);
      $display("register test done");
    end
  endtask
  task t_tx;
    reg [15:0] w;
    integer    i;
    begin
      w = {1'b0, 6'h25, 1'b0, 8'hff};
      wr(8'hc1, 8'h25);
      wr(8'h37, 8'h01);
      repeat (2) @(posedge mclk_i);
      for (i = 0; i < 32; i = i + 1) begin
        FAR.take(b);
        chk({7'h00, b}, {7'h00, w[i % 16]});
      end
      rdm(8'h24, 8'h04, 8'h04);
      wr(8'h37, 8'h00);
      for (i = 0; i < 20; i = i + 1) begin
        if (i == 10) begin
          t1_mode_i = 1'b0;
          wr(8'h37, 8'h01);
        end
        FAR.take(b);
        chk({7'h00, b}, 8'h01);
      end
      wr(8'h37, 8'h00);
      t1_mode_i = 1'b1;
      $display("transmit test done");
    end
  endtask
  task t_rx;
    integer f;
    integer k;
    begin
      wr(8'hc2, 8'h2a);
      wr(8'h25, 8'h01);
      for (f = 0; f < 4; f = f + 1) begin
        wr(8'h37, 8'h00);
        wr(8'h37, {4'b0001, 1'b0, f[1:0], 1'b0});
        for (k = 0; k < 2 * f; k = k + 1)
          FAR.word(6'h2a);
        repeat (4) @(posedge mclk_i);
        rdm(8'hc0, 8'hff, 8'h3f);
        FAR.word(6'h2a);
        repeat (4) @(posedge mclk_i);
        rdm(8'hc0, 8'hff, 8'h2a);
      end
      chk({7'h00, irq_n_o}, 8'h00);
      rdm(8'h14, 8'h80, 8'h80);
      wr(8'h25, 8'h00);
      chk({7'h00, irq_n_o}, 8'h01);
      rdm(8'h24, 8'h1b, 8'h1b);
      // lost words drive the detector back to no code
      FAR.zeros(32);
      repeat (4) @(posedge mclk_i);
      rdm(8'h24, 8'h21, 8'h21);
      rdm(8'hc0, 8'hff, 8'h3f);
      // second match register alone must raise the match event
      wr(8'hc2, 8'h00);
      wr(8'hc3, 8'h2a);
      for (k = 0; k < 7; k = k + 1)
        FAR.word(6'h2a);
      repeat (4) @(posedge mclk_i);
      rdm(8'hc0, 8'hff, 8'h2a);
      rdm(8'h24, 8'h0b, 8'h0b);
      wr(8'h37, 8'h1e);
      repeat (2) @(posedge mclk_i);
      rdm(8'hc0, 8'hff, 8'h3f);
      wr(8'h37, 8'h00);
      $display("receive test done");
    end
  endtask
  task t_rst;
    begin
      wr(8'h25, 8'h3f);
      wr(8'hc1, 8'h15);
      wr(8'h37, 8'h11);
      repeat (3) @(posedge mclk_i);
      #1;
      chk({7'h00, irq_n_o}, 8'h00);
      // mid-run reset must return mask, control, tx message, status, rx code, irq and tx line to idle
      rst_n_i = 1'b0;
      repeat (2) @(posedge mclk_i);
      #1;
      rst_n_i = 1'b1;
      chk({7'h00, irq_n_o}, 8'h01);
      rdm(8'h25, 8'hff, 8'h00);
      rdm(8'h37, 8'hff, 8'h00);
      rdm(8'hc1, 8'hff, 8'h00);
      rdm(8'h24, 8'hff, 8'h00);
      rdm(8'hc0, 8'hff, 8'h3f);
      FAR.take(b);
      chk({7'h00, b}, 8'h01);
      $display("reset test done");
    end
  endtask
  task conclude;
    begin
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    mclk_i = 1'b0;
    rst_n_i = 1'b0;
    t1_mode_i = 1'b1;
    addr_i = 8'h00;
    wr_i = 1'b0;
    wdata_i = 8'h00;
    rd_i = 1'b0;
    fails = 0;
    n_compared = 0;
    repeat (4) @(posedge mclk_i);
    #1;
    rst_n_i = 1'b1;
    t_regs;
    t_tx;
    t_rx;
    t_rst;
    conclude;
  end
  // tests need under 10k cycles, so 100 us means a hang
  initial begin
    #100000;
    fails = fails + 1;
    conclude;
  end
endmodule
